// [common/src_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Source clock request from the channel and the tick answer
interface src_tick_if;
  tmr_pkg::src_t sel;     // Selected source clock
  logic          presel;  // Slowest source from low clock when set
  logic          slow;    // Low frequency clock is the only one running
  logic          tick;    // One cycle pulse per source clock period

  modport channel (output sel, output presel, output slow, input tick);
  modport prescaler (input sel, input presel, input slow, output tick);
endinterface : src_tick_if

`default_nettype wire

// [common/tmr_pkg.sv]
`default_nettype none
package tmr_pkg;

  // Register byte offsets on the 32-bit bus, one aligned word each
  localparam logic [3:0] OFF_CTRL    = 4'h0;
  localparam logic [3:0] OFF_COMPARE = 4'h4;
  localparam logic [3:0] OFF_DUTY    = 4'h8;
  localparam logic [3:0] OFF_STATUS  = 4'hc;

  // Control register field positions
  localparam int CTRL_FF_BIT     = 7;
  localparam int CTRL_SRC_HI     = 6;
  localparam int CTRL_SRC_LO     = 4;
  localparam int CTRL_START_BIT  = 3;
  localparam int CTRL_MODE_HI    = 2;
  localparam int CTRL_MODE_LO    = 0;
  localparam int CTRL_PRESEL_BIT = 8;

  // Status register field positions
  localparam int STAT_CNT_HI  = 7;
  localparam int STAT_FF_BIT  = 8;
  localparam int STAT_PEND_BIT = 9;

  // Reset values and the counter maximum
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'hff;
  localparam logic [7:0] DUTY_RESET    = 8'h80;
  localparam logic [7:0] CNT_MAX       = 8'hff;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_TIMER   = 3'h0,
    MODE_DIVIDER = 3'h1,
    MODE_PWM     = 3'h2,
    MODE_EVENT   = 3'h3
  } mode_t;

  // Source clock selections
  typedef enum logic [2:0] {
    SRC_SLOWEST = 3'h0,
    SRC_DIV7    = 3'h1,
    SRC_DIV5    = 3'h2,
    SRC_DIV3    = 3'h3,
    SRC_LOW     = 3'h4,
    SRC_DIV1    = 3'h5,
    SRC_FULL    = 3'h6,
    SRC_PIN     = 3'h7
  } src_t;

  // Prescaler exponents of the high frequency clock, and of the low clock divider (EXP_LOW3)
  localparam int EXP_SLOWEST = 11;
  localparam int EXP_DIV7    = 7;
  localparam int EXP_DIV5    = 5;
  localparam int EXP_DIV3    = 3;
  localparam int EXP_DIV1    = 1;
  localparam int EXP_LOW3    = 3;

endpackage : tmr_pkg
`default_nettype wire

// [src/timer6_event_pdo_pwm.sv]
// Behaviour
// - Event mode counts falling edges of input pin
// - Event match raises interrupt, clears, keeps counting
// - Compare register unbuffered; software avoids running writes
// - Divider match toggles flip-flop, clears, interrupts
// - Divider pin is inverted flip-flop, reset zero
// - Stopped divider keeps level; later write changes
// - Bit7 clear drives pin high; bit3 clear stops
// - Control write selects source, mode and start
// - PWM toggles on duty match and overflow
// - PWM pin inverted flip-flop; initial value polarity
// - Duty buffered; moves at interrupt or immediately
// - Duty reads return active value while running
// - Stopped PWM holds level; later write changes
// - PWM sources selectable, slow mode limits them
`timescale 1ns/1ps
`default_nettype none

module timer6_event_pdo_pwm #(
  parameter int ADR_W = 4
) (
  input  wire logic             I_SYS_CLK,
  input  wire logic             I_RST_B,
  // Classic Wishbone slave
  input  wire logic             I_WB_CYC,
  input  wire logic             I_WB_STB,
  input  wire logic             I_WB_WE,
  input  wire logic [ADR_W-1:0] I_WB_ADR,
  input  wire logic [3:0]       I_WB_SEL,
  input  wire logic [31:0]      I_WB_DAT,
  output logic      [31:0]      O_WB_DAT,
  output logic                  O_WB_ACK,
  // Channel pins and system state
  input  wire logic             I_COUNT_INPUT_PIN,
  input  wire logic             I_LOW_FREQ_CLOCK,
  input  wire logic             I_SLOW_RUN_MODE,
  output logic                  O_DIVIDER_OUT_PIN_B,
  output logic                  O_PWM_OUT_PIN_B,
  output logic                  O_CHANNEL_IRQ
);

  // Reset synchroniser
  logic rst_meta_q;  // First stage, read only by the second
  logic rst_n;       // Released reset used by the whole block

  // Wishbone state
  logic        ack_q;       // Acknowledge, one cycle per request
  logic [31:0] rdata_q;     // Registered read data
  logic        req;         // Request is present
  logic        wr_take;     // Write takes effect at this edge
  logic [3:0]  adr_byte;    // Byte address of the request

  // Channel state
  logic [7:0]  ctrl_q;      // channel_ctrl_reg low byte
  logic        presel_q;    // prescale_select_bit
  logic [7:0]  compare_reg_q; // Compare value, unbuffered
  logic [7:0]  duty_buf_q;  // Written duty value
  logic [7:0]  duty_act_q;  // Active duty compare
  logic        duty_pend_q; // Buffered duty waits for transfer
  logic [7:0]  cnt_q;       // Up-counter
  logic        ff_q;        // Output flip-flop
  logic        irq_q;       // Interrupt pulse
  logic        pin_prev_q;  // Last sampled count input level

  // Decoded fields and events
  tmr_pkg::mode_t mode;     // Current mode
  logic        running;     // Start bit
  logic        pin_fall;    // Falling edge on the count input
  logic        step;        // Counter advances this cycle
  logic [7:0]  cnt_next;    // Counter plus one
  logic        cmp_match;   // Counter reaches the compare value
  logic        duty_match;  // Counter reaches the active duty
  logic        overflow;    // Counter wraps in PWM mode
  logic        clear_evt;   // Counter clear with interrupt
  logic        wr_ctrl;     // Control register write
  logic        wr_cmp;      // Compare register write
  logic        wr_duty;     // Duty register write
  logic [7:0]  ctrl_new;    // Control value after a write

  src_tick_if src_if ();    // Link to the prescaler

  // Two flop release of the asynchronous reset
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Source clock ticks from the shared prescaler
  tmr_prescaler u_prescaler (
    .i_clk     (I_SYS_CLK),
    .i_rst_n   (rst_n),
    .i_low_clk (I_LOW_FREQ_CLOCK),
    .src       (src_if.prescaler)
  );

  // Source select feeds the prescaler; slow mode limits sources
  assign src_if.sel    = tmr_pkg::src_t'(ctrl_q[tmr_pkg::CTRL_SRC_HI:
                                                tmr_pkg::CTRL_SRC_LO]);
  assign src_if.presel = presel_q;
  assign src_if.slow   = I_SLOW_RUN_MODE;

  // Bus decode
  assign req      = I_WB_CYC & I_WB_STB;
  assign adr_byte = {I_WB_ADR[3:2], 2'b00};
  assign wr_take  = req & I_WB_WE & ack_q;
  assign wr_ctrl  = wr_take & I_WB_SEL[0] & (adr_byte == tmr_pkg::OFF_CTRL);
  assign wr_cmp   = wr_take & I_WB_SEL[0]
                  & (adr_byte == tmr_pkg::OFF_COMPARE);
  assign wr_duty  = wr_take & I_WB_SEL[0] & (adr_byte == tmr_pkg::OFF_DUTY);
  assign ctrl_new = I_WB_DAT[7:0];

  // Field decode
  assign mode    = tmr_pkg::mode_t'(ctrl_q[tmr_pkg::CTRL_MODE_HI:
                                           tmr_pkg::CTRL_MODE_LO]);
  assign running = ctrl_q[tmr_pkg::CTRL_START_BIT];

  // Falling edge of the count input, already synchronous to the clock
  assign pin_fall = pin_prev_q & ~I_COUNT_INPUT_PIN;

  // Event mode counts the pin, divider and PWM modes the selected source tick, timer mode does not count
  always_comb begin
    step = 1'b0;
    if (running) begin
      case (mode)
        tmr_pkg::MODE_EVENT:   step = pin_fall;
        tmr_pkg::MODE_DIVIDER: step = src_if.tick;
        tmr_pkg::MODE_PWM:     step = src_if.tick;
        default:               step = 1'b0;
      endcase
    end
  end

  assign cnt_next   = cnt_q + 8'h01;
  assign cmp_match  = (cnt_next == compare_reg_q);
  assign duty_match = (cnt_next == duty_act_q);
  assign overflow   = (cnt_q == tmr_pkg::CNT_MAX);

  // Clear event of the event, divider and PWM modes, which is also the interrupt event
  always_comb begin
    clear_evt = 1'b0;
    if (step) begin
      case (mode)
        tmr_pkg::MODE_EVENT:   clear_evt = cmp_match;
        tmr_pkg::MODE_DIVIDER: clear_evt = cmp_match;
        tmr_pkg::MODE_PWM:     clear_evt = overflow;
        default:               clear_evt = 1'b0;
      endcase
    end
  end

  // Wishbone acknowledge one cycle after the request, then dropped
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read data captured as the request arrives; unmapped reads zero
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      case (adr_byte)
        tmr_pkg::OFF_CTRL: begin
          rdata_q <= {23'h000000, presel_q, ctrl_q};
        end
        tmr_pkg::OFF_COMPARE: begin
          rdata_q <= {24'h000000, compare_reg_q};
        end
        tmr_pkg::OFF_DUTY: begin
          // Active value; buffer and active match after a write while stopped
          rdata_q <= {24'h000000, duty_act_q};
        end
        tmr_pkg::OFF_STATUS: begin
          rdata_q <= {22'h000000, duty_pend_q, ff_q, cnt_q};
        end
        default: begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Control register; a stop keeps the running value otherwise
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= tmr_pkg::CTRL_RESET;
      presel_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_new;
      end
      if (wr_take && I_WB_SEL[1] && adr_byte == tmr_pkg::OFF_CTRL) begin
        presel_q <= I_WB_DAT[tmr_pkg::CTRL_PRESEL_BIT];
      end
    end
  end

  // Compare register takes a write at once, with no shadow copy
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      compare_reg_q <= tmr_pkg::COMPARE_RESET;
    end else if (wr_cmp) begin
      compare_reg_q <= I_WB_DAT[7:0];
    end
  end

  // Duty double buffer; a write that meets the transfer is kept
  // pending, so the older buffered value moves and the new one
  // follows at the next overflow rather than being lost.
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      duty_buf_q  <= tmr_pkg::DUTY_RESET;
      duty_act_q  <= tmr_pkg::DUTY_RESET;
      duty_pend_q <= 1'b0;
    end else begin
      if (clear_evt && mode == tmr_pkg::MODE_PWM && duty_pend_q) begin
        duty_act_q <= duty_buf_q;
      end
      if (wr_duty) begin
        duty_buf_q <= I_WB_DAT[7:0];
        if (!running) begin
          duty_act_q  <= I_WB_DAT[7:0];
          duty_pend_q <= 1'b0;
        end else begin
          duty_pend_q <= 1'b1;
        end
      end else if (clear_evt && mode == tmr_pkg::MODE_PWM) begin
        duty_pend_q <= 1'b0;
      end
    end
  end

  // Up-counter; a stopped channel holds its count, a start from
  // stopped begins again at zero
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (wr_ctrl && !running) begin
      cnt_q <= 8'h00;
    end else if (clear_evt) begin
      cnt_q <= 8'h00;
    end else if (step) begin
      cnt_q <= cnt_next;
    end
  end

  // Output flip-flop. Software loads it only while the channel was
  // stopped before the write, so the stop write leaves the pin as it
  // was and a later write sets the level.
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ff_q <= 1'b0;
    end else if (wr_ctrl && !running) begin
      ff_q <= ctrl_new[tmr_pkg::CTRL_FF_BIT];
    end else if (step) begin
      case (mode)
        tmr_pkg::MODE_DIVIDER: begin
          if (cmp_match) begin
            ff_q <= ~ff_q;
          end
        end
        tmr_pkg::MODE_PWM: begin
          // Overflow wins when the duty also matches the wrap
          if (overflow || duty_match) begin
            ff_q <= ~ff_q;
          end
        end
        default: begin
          ff_q <= ff_q;
        end
      endcase
    end
  end

  // Interrupt pulse appears with the cleared counter
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= clear_evt;
    end
  end

  // Count input history for edge detection
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= I_COUNT_INPUT_PIN;
    end
  end

  // Both pins show the inverted flip-flop in every mode, which is
  // why a set flip-flop in event mode shows on the pins.
  assign O_DIVIDER_OUT_PIN_B = ~ff_q;
  assign O_PWM_OUT_PIN_B     = ~ff_q;
  assign O_CHANNEL_IRQ       = irq_q;
  assign O_WB_ACK            = ack_q;
  assign O_WB_DAT            = rdata_q;

endmodule : timer6_event_pdo_pwm

`default_nettype wire

// [src/tmr_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none

// Divides the system clock into the selectable source clock ticks
module tmr_prescaler (
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  input  wire logic   i_low_clk,
  src_tick_if.prescaler src
);

  logic [10:0] div_q;      // Free running divider of the high clock
  logic [2:0]  low_div_q;  // Divider of the low clock by eight
  logic        low_prev_q; // Last level of the low clock
  logic        low_edge;   // Rising edge of the low clock
  logic        low_div3;   // Low clock divided by eight
  logic        tick_d;     // Selected tick before its flop
  logic        tick_q;     // Registered tick

  assign low_edge = i_low_clk & ~low_prev_q;
  assign low_div3 = low_edge & (&low_div_q);

  // High clock divider chain
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 11'h000;
    end else begin
      div_q <= div_q + 11'h001;
    end
  end

  // Low clock edge detect and divide by eight
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_prev_q <= 1'b0;
      low_div_q  <= 3'h0;
    end else begin
      low_prev_q <= i_low_clk;
      if (low_edge) begin
        low_div_q <= low_div_q + 3'h1;
      end
    end
  end

  // Tick selection; in slow operation the high clock is stopped
  always_comb begin
    tick_d = 1'b0;
    case (src.sel)
      tmr_pkg::SRC_SLOWEST: begin
        if (src.presel || src.slow) begin
          tick_d = low_div3;
        end else begin
          tick_d = &div_q[tmr_pkg::EXP_SLOWEST-1:0];
        end
      end
      tmr_pkg::SRC_DIV7: tick_d = ~src.slow & (&div_q[tmr_pkg::EXP_DIV7-1:0]);
      tmr_pkg::SRC_DIV5: tick_d = ~src.slow & (&div_q[tmr_pkg::EXP_DIV5-1:0]);
      tmr_pkg::SRC_DIV3: tick_d = ~src.slow & (&div_q[tmr_pkg::EXP_DIV3-1:0]);
      tmr_pkg::SRC_LOW:  tick_d = low_edge;
      tmr_pkg::SRC_DIV1: tick_d = ~src.slow & div_q[0];
      tmr_pkg::SRC_FULL: tick_d = ~src.slow;
      default:           tick_d = 1'b0;
    endcase
  end

  // Registered; the tick is one cycle wide for every source except SRC_FULL, where it stays high
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end

  assign src.tick = tick_q;

endmodule : tmr_prescaler

`default_nettype wire

// [testbench/pulse_source.sv]
`timescale 1ns/1ps
`default_nettype none
// External pulse source on the count input, plus a free low clock
module pulse_source (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_req,   // Load a burst
  input  wire logic [7:0] i_num,   // Pulses in the burst
  output logic            o_pin,   // Count input, idles high
  output logic            o_low_clk,
  output logic            o_busy
);
  logic [7:0] left_q;  // Pulses still to send
  logic [1:0] ph_q;    // Cycles into this phase
  logic [2:0] lck_q;   // Low clock divider, runs free
  // Phases last three cycles, above the two-cycle minimum
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      left_q <= 8'h00;
      ph_q   <= 2'h0;
      o_pin  <= 1'b1;
      lck_q  <= 3'h0;
    end else begin
      lck_q <= lck_q + 3'h1;
      if (i_req) begin
        left_q <= i_num;
        ph_q   <= 2'h0;
      end else if (left_q != 8'h00) begin
        ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
        if (ph_q == 2'h2) begin
          o_pin <= ~o_pin;
          // A pulse ends when the line returns high
          if (!o_pin) left_q <= left_q - 8'h01;
        end
      end
    end
  end
  assign o_low_clk = lck_q[2];
  assign o_busy    = (left_q != 8'h00);
endmodule : pulse_source
`default_nettype wire

// [testbench/test_timer6_event_pdo_pwm.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module test_timer6_event_pdo_pwm;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        slow = 1'b0;
  logic        req = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [7:0]  num = 8'h00;
  logic [7:0]  rnd = 8'd23;
  logic [31:0] rdat;
  logic        ack, irq, div_b, pwm_b, cpin, lclk, busy, s;
  logic [7:0]  q[$];
  logic [7:0]  e;
  int          num_errors = 0;
  int          compares = 0;
  int          irqs = 0;
  int          n, i0;
  always #25 clk = ~clk;
  timer6_event_pdo_pwm u_dut (.I_SYS_CLK(clk), .I_RST_B(rst_b),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_COUNT_INPUT_PIN(cpin), .I_LOW_FREQ_CLOCK(lclk),
    .I_SLOW_RUN_MODE(slow), .O_DIVIDER_OUT_PIN_B(div_b),
    .O_PWM_OUT_PIN_B(pwm_b), .O_CHANNEL_IRQ(irq));
  pulse_source u_src (.i_clk(clk), .i_rst_b(rst_b), .i_req(req),
    .i_num(num), .o_pin(cpin), .o_low_clk(lclk), .o_busy(busy));
  // Watcher: counts interrupts and checks read data against notes
  always @(posedge clk) begin
    if (irq === 1'b1) irqs++;
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      `CHK("read", e, rdat[7:0])
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // Classic single cycle; held until ack, then released
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'h3;
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin num_errors++; stop_test(); end
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    q.push_back(x);
    wb(a, 1'b0, 32'h0);
  endtask : rd
  // Cycles from one pin change to the next
  task automatic gap(output int c);
    logic [1:0] v;
    c = 0;
    @(negedge clk);
    v = {div_b, pwm_b};
    while ({div_b, pwm_b} === v && c < 3000) begin @(negedge clk); c++; end
    c++;
    if (c >= 3000) begin num_errors++; stop_test(); end
  endtask : gap
  task automatic pulses(input logic [7:0] k);
    int c;
    c = 0;
    @(posedge clk);
    req <= 1'b1;
    num <= k;
    @(posedge clk);
    req <= 1'b0;
    do begin @(negedge clk); c++; end while (busy === 1'b1 && c < 5000);
    if (c >= 5000) begin num_errors++; stop_test(); end
  endtask : pulses
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("div pin", 1'b1, div_b)
    `CHK("pwm pin", 1'b1, pwm_b)
    rd(4'h0, 8'h00);
    rd(4'h4, 8'hff);
    rd(4'h8, tmr_pkg::DUTY_RESET);
    $display("reset test done");
    // Divider at the /2^7 source; output latch loaded clear, pin high
    wb(4'h4, 1'b1, 32'h3);
    wb(4'h0, 1'b1, 32'h11);
    repeat (400) @(posedge clk);
    `CHK("stopped irqs", 0, irqs)
    wb(4'h0, 1'b1, 32'h19);
    gap(n);
    gap(n);
    `CHK("pdo half", 3 * (1 << tmr_pkg::EXP_DIV7), n)
    gap(n);
    wb(4'h0, 1'b1, 32'h11);
    repeat (800) @(posedge clk);
    `CHK("pdo irqs", 3, irqs)
    `CHK("pdo hold", 1'b0, div_b)
    wb(4'h0, 1'b1, 32'h11);
    repeat (3) @(posedge clk);
    `CHK("pdo high", 1'b1, div_b)
    $display("divider test done");
    // Event counter, random compare of 2 to 9, flip-flop bit kept 0
    rnd = lfsr(rnd);
    wb(4'h4, 1'b1, {29'h0, rnd[2:0]} + 32'h2);
    wb(4'h0, 1'b1, 32'h7b);
    i0 = irqs;
    pulses(8'(2 * (rnd[2:0] + 2) + 1));
    repeat (4) @(posedge clk);
    `CHK("ev irqs", 2, irqs - i0)
    rd(4'hc, 8'h01);
    wb(4'h0, 1'b1, 32'h73);
    $display("event test done");
    // PWM at full rate; duty loads at once while stopped
    wb(4'h0, 1'b1, 32'h62);
    wb(4'h8, 1'b1, 32'h40);
    rd(4'h8, 8'h40);
    wb(4'h0, 1'b1, 32'h6a);
    gap(n);
    gap(n);
    `CHK("pwm low", 192, n)
    wb(4'h8, 1'b1, 32'h20);
    rd(4'h8, 8'h40);
    // Partial phase first: the write and read above used some cycles
    gap(n);
    gap(n);
    `CHK("pwm old", 256 - 64, n)
    gap(n);
    `CHK("pwm new", 32, n)
    rd(4'h8, 8'h20);
    wb(4'h0, 1'b1, 32'h62);
    s = pwm_b;
    repeat (300) @(posedge clk);
    `CHK("pwm hold", s, pwm_b)
    wb(4'h0, 1'b1, 32'he2);
    repeat (3) @(posedge clk);
    `CHK("pwm init", 1'b0, pwm_b)
    wb(4'h0, 1'b1, 32'h62);
    // Slow mode leaves the fast sources without ticks
    slow <= 1'b1;
    wb(4'h0, 1'b1, 32'h6a);
    repeat (50) @(posedge clk);
    rd(4'hc, 8'h00);
    wb(4'h0, 1'b1, 32'h62);
    // Low clock source still ticks, one rising edge per 8 cycles here
    wb(4'h0, 1'b1, 32'h4a);
    gap(n);
    gap(n);
    `CHK("low src", (256 - 32) * 8, n)
    wb(4'h0, 1'b1, 32'h42);
    slow <= 1'b0;
    $display("pwm test done");
    stop_test();
  end
endmodule : test_timer6_event_pdo_pwm
`default_nettype wire

// [testbench/timer6_event_pdo_pwm_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Port checker; shadows control writes to learn mode and run state
module timer6_assertions #(
  parameter int ADR_W = 4
) (
  input wire logic             I_SYS_CLK,
  input wire logic             I_RST_B,
  input wire logic             I_WB_CYC,
  input wire logic             I_WB_STB,
  input wire logic             I_WB_WE,
  input wire logic [ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0]       I_WB_SEL,
  input wire logic [31:0]      I_WB_DAT,
  input wire logic [31:0]      O_WB_DAT,
  input wire logic             O_WB_ACK,
  input wire logic             I_COUNT_INPUT_PIN,
  input wire logic             I_LOW_FREQ_CLOCK,
  input wire logic             I_SLOW_RUN_MODE,
  input wire logic             O_DIVIDER_OUT_PIN_B,
  input wire logic             O_PWM_OUT_PIN_B,
  input wire logic             O_CHANNEL_IRQ
);
  logic [2:0] mode_q;  // Mode of last control write
  logic       run_q;   // Start bit of last control write
  logic       pin_q;   // Count input one cycle back
  logic [3:0] fall_q;  // Cycles since the input fell
  logic [3:0] age_q;   // Cycles since the last ack
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_B);
  // Shadow state, taken at the edge where a write lands
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mode_q <= 3'h0;
      run_q  <= 1'b0;
      pin_q  <= 1'b1;
      fall_q <= 4'hf;
      age_q  <= 4'h0;
    end else begin
      if (I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK && I_WB_SEL[0] &&
          I_WB_ADR[3:2] == 2'h0) begin
        mode_q <= I_WB_DAT[2:0];
        run_q  <= I_WB_DAT[3];
      end
      pin_q  <= I_COUNT_INPUT_PIN;
      // Saturate so a quiet input never wraps back to a fresh edge
      fall_q <= (pin_q && !I_COUNT_INPUT_PIN) ? 4'h0 :
                (fall_q == 4'hf) ? 4'hf : fall_q + 4'h1;
      age_q  <= O_WB_ACK ? 4'h0 : (age_q == 4'hf) ? 4'hf : age_q + 4'h1;
    end
  end
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK
    |=> O_WB_ACK)
    else $error("request not acked next cycle");
  ack_idle_a: assert property (!(I_WB_CYC && I_WB_STB) |=> !O_WB_ACK)
    else $error("ack without request");
  reset_pins_a: assert property ($rose(I_RST_B) |->
    O_DIVIDER_OUT_PIN_B && O_PWM_OUT_PIN_B && !O_CHANNEL_IRQ)
    else $error("outputs not at reset level");
  // A write landing while stopped may load the flip-flop, so skip it
  stop_hold_a: assert property (!run_q && age_q > 4'h3 &&
    !O_WB_ACK |=> $stable({O_DIVIDER_OUT_PIN_B, O_PWM_OUT_PIN_B}))
    else $error("pin moved while stopped");
  stop_quiet_a: assert property (!run_q && age_q > 4'h3 |->
    !O_CHANNEL_IRQ)
    else $error("interrupt while stopped");
  div_irq_pair_a: assert property ($changed(O_DIVIDER_OUT_PIN_B) &&
    mode_q == 3'h1 && run_q && age_q > 4'h2 |->
    O_CHANNEL_IRQ || $past(O_CHANNEL_IRQ) || $past(O_CHANNEL_IRQ, 2))
    else $error("divider toggle without interrupt");
  ev_irq_cause_a: assert property (O_CHANNEL_IRQ && mode_q == 3'h3 &&
    run_q |-> fall_q < 4'h5)
    else $error("event interrupt without input edge");
endmodule : timer6_assertions
bind timer6_event_pdo_pwm timer6_assertions #(.ADR_W(ADR_W)) u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .I_COUNT_INPUT_PIN(I_COUNT_INPUT_PIN),
  .I_LOW_FREQ_CLOCK(I_LOW_FREQ_CLOCK), .I_SLOW_RUN_MODE(I_SLOW_RUN_MODE),
  .O_DIVIDER_OUT_PIN_B(O_DIVIDER_OUT_PIN_B),
  .O_PWM_OUT_PIN_B(O_PWM_OUT_PIN_B), .O_CHANNEL_IRQ(O_CHANNEL_IRQ));
`default_nettype wire
